// file: upec_pkg.sv
// package for the serial port operation-mode control block
// assumes a cpu-side byte register port and a 50 MHz peripheral clock
package upec_pkg;

    // ************************************************************
    // register map and field layout
    // ************************************************************
    localparam logic [15:0] SERIAL_OPERATION_MODE_ADDR = 16'hff70;
    localparam logic [7:0]  SERIAL_OPERATION_MODE_RESET = 8'h01;
    localparam int          PORT_CLOCK_POWER_BIT        = 7;
    localparam int          TRANSMIT_ENABLE_BIT_POS     = 6;
    localparam int          RECEIVE_ENABLE_BIT_POS      = 5;
    localparam int          PARITY_SELECT_HIGH_BIT      = 4;
    localparam int          PARITY_SELECT_LOW_BIT       = 3;
    localparam int          CHARACTER_LENGTH_BIT        = 2;
    localparam int          STOP_LENGTH_BIT             = 1;
    localparam int          FIXED_ONE_BIT               = 0;
    localparam logic [7:0]  WRITABLE_MASK               = 8'hfe;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        UPEC_STOPPED,
        UPEC_ACTIVE
    } upec_mode_e;

    // cpu write request: byte write or single-bit write
    typedef struct packed {
        logic        wr;
        logic        bit_wr;
        logic [2:0]  bit_sel;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } upec_req_s;

    // controls handed to the transmitter and receiver cores
    typedef struct packed {
        logic       clk_run;
        logic       async_clr_n;
        logic       tx_sync_clr;
        logic       rx_sync_clr;
        logic [1:0] parity_select;
        logic       character_length_select;
        logic       stop_length_select;
    } upec_ctrl_s;

endpackage : upec_pkg

// file: upec_ctrl.sv
// operation-mode control for the asynchronous serial port
// assumes cpu accesses are synchronous to clk; pins arrive asynchronously
//
// Summary of operation
// - port is either stopped or active asynchronous transmit/receive
// - all of clock power, transmit and receive enable zero means stopped
// - stopped port releases its transmit and receive pins to the port logic
// - mode register at FF70H: power, tx, rx enables, parity, length, stop
// - system reset loads 01H, clearing clock power and both enables
// - register accepts single-bit and whole-byte writes
// - clock power zero stops the clock low and resets the port asynchronously
// - that reset clears error status, transmit shift and receive buffer
// - with clock power zero the receiver sees its input held high
// - transmit enable zero disables and synchronously resets the transmitter
// - receive enable zero disables and synchronously resets the receiver
module upec_ctrl #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire upec_pkg::upec_req_s req,
    output logic [7:0]               rdata,
    input  wire logic [15:0]         raddr,
    input  wire logic                serial_input_pin,
    input  wire logic                tx_data_from_core,
    output logic                     serial_output_pin,
    output logic                     serial_output_oe,
    output logic                     rx_data_to_core,
    output logic                     port_pins_released,
    output logic                     gated_clock,
    output upec_pkg::upec_ctrl_s     ctrl,
    output upec_pkg::upec_mode_e     mode
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // fewer than two stages would let a metastable pin level reach the receiver
    if (SYNC_STAGES < 2) begin : g_check_sync
        $error("upec_ctrl: SYNC_STAGES must be at least 2");
    end

    // ************************************************************
    // mode register
    // ************************************************************
    logic [7:0] serial_operation_mode;
    logic [7:0] next_mode_reg;
    logic       hit;

    function automatic logic [7:0] upec_bit_merge(input logic [7:0] old,
                                                  input logic [2:0] sel,
                                                  input logic       val);
        logic [7:0] res;
        res      = old;
        res[sel] = val;
        return res;
    endfunction

    // one decode shared by the write and the read side
    function automatic logic upec_addr_hit(input logic [15:0] a);
        return a == upec_pkg::SERIAL_OPERATION_MODE_ADDR;
    endfunction

    assign hit = req.wr && upec_addr_hit(req.addr);

    always_comb begin
        if (req.bit_wr) begin
            next_mode_reg = upec_bit_merge(serial_operation_mode, req.bit_sel,
                                           req.wdata[0]);
        end else begin
            next_mode_reg = req.wdata;
        end
        // bit 0 is wired to one whatever is written
        next_mode_reg = (next_mode_reg & upec_pkg::WRITABLE_MASK)
                        | upec_pkg::SERIAL_OPERATION_MODE_RESET;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_operation_mode <= upec_pkg::SERIAL_OPERATION_MODE_RESET;
        end else if (hit) begin
            serial_operation_mode <= next_mode_reg;
        end
    end

    // reads: unmapped addresses return zero
    always_comb begin
        if (upec_addr_hit(raddr)) begin
            rdata = serial_operation_mode;
        end else begin
            rdata = 8'h00;
        end
    end

    // ************************************************************
    // decoded controls
    // ************************************************************
    logic power_on;
    logic tx_en;
    logic rx_en;

    assign power_on = serial_operation_mode[upec_pkg::PORT_CLOCK_POWER_BIT];
    assign tx_en    = serial_operation_mode[upec_pkg::TRANSMIT_ENABLE_BIT_POS];
    assign rx_en    = serial_operation_mode[upec_pkg::RECEIVE_ENABLE_BIT_POS];

    // stopped only when all three are clear; other mixes are misuse by software
    always_comb begin
        if (!power_on && !tx_en && !rx_en) begin
            mode = upec_pkg::UPEC_STOPPED;
        end else begin
            mode = upec_pkg::UPEC_ACTIVE;
        end
    end

    // ************************************************************
    // clock gate, async clear and sync clears
    // ************************************************************
    // latch-free gate: enable sampled on the falling edge so the gated clock has no glitch
    logic gate_en;

    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_en <= 1'b0;
        end else begin
            gate_en <= power_on;
        end
    end

    assign gated_clock = clk & gate_en;

    // tx/rx sync clears follow the enables alone, not qualified by power; the cores rely on software ordering
    // power first on start, enables first on stop, so no half-reset state arises
    always_comb begin
        ctrl.clk_run                 = gate_en;
        ctrl.async_clr_n             = rst_n & power_on;
        ctrl.tx_sync_clr             = ~tx_en;
        ctrl.rx_sync_clr             = ~rx_en;
        ctrl.parity_select           = serial_operation_mode[upec_pkg::PARITY_SELECT_HIGH_BIT:
                                                             upec_pkg::PARITY_SELECT_LOW_BIT];
        ctrl.character_length_select = serial_operation_mode[upec_pkg::CHARACTER_LENGTH_BIT];
        ctrl.stop_length_select      = serial_operation_mode[upec_pkg::STOP_LENGTH_BIT];
    end

    // ************************************************************
    // serial pins
    // ************************************************************
    // pin synchroniser; resets to the idle high level so no false start bit follows reset
    logic [SYNC_STAGES-1:0] rx_sync;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync <= '1;
        end else begin
            rx_sync <= {rx_sync[SYNC_STAGES-2:0], serial_input_pin};
        end
    end

    // receiver sees idle high whenever clock power is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_to_core <= 1'b1;
        end else if (!power_on) begin
            rx_data_to_core <= 1'b1;
        end else begin
            rx_data_to_core <= rx_sync[SYNC_STAGES-1];
        end
    end

    // transmit line idles high while power is on but transmitter disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_output_pin <= 1'b1;
        end else begin
            serial_output_pin <= tx_en ? tx_data_from_core : 1'b1;
        end
    end

    // output enable lags the mode by one edge; the pin is idle high by then
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_output_oe <= 1'b0;
        end else begin
            serial_output_oe <= (mode != upec_pkg::UPEC_STOPPED);
        end
    end

    assign port_pins_released = (mode == upec_pkg::UPEC_STOPPED);

endmodule : upec_ctrl

// file: upec_chk.sv
// checker: timing relations of the mode register and the controls it drives
// assumes it is bound into upec_ctrl and sees only that module's ports
module upec_chk (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire upec_pkg::upec_req_s  req,
    input wire logic [7:0]           rdata,
    input wire logic [15:0]          raddr,
    input wire logic                 serial_output_pin,
    input wire logic                 serial_output_oe,
    input wire logic                 rx_data_to_core,
    input wire logic                 port_pins_released,
    input wire upec_pkg::upec_ctrl_s ctrl,
    input wire upec_pkg::upec_mode_e mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic stop = (mode == upec_pkg::UPEC_STOPPED);
    wire logic rd   = (raddr == 16'hff70);
    sequence s_byte; req.wr && !req.bit_wr && req.addr == 16'hff70 ##1 rd; endsequence
    sequence s_bit; req.wr && req.bit_wr && req.addr == 16'hff70 ##1 rd; endsequence
    property p_byte; s_byte |-> rdata == {$past(req.wdata[7:1]), 1'b1}; endproperty
    a_byte: assert property (p_byte) else $error("byte write lost");
    property p_bit;
        s_bit |-> rdata[$past(req.bit_sel)] ==
                  ($past(req.wdata[0]) || $past(req.bit_sel) == 3'h0);
    endproperty
    a_bit: assert property (p_bit) else $error("bit write lost");
    property p_unm; req.wr && req.addr != 16'hff70 && rd ##1 rd |-> $stable(rdata); endproperty
    a_unm: assert property (p_unm) else $error("foreign write hit");
    property p_stop; rd |-> stop == (rdata[7:5] == 3'h0); endproperty
    a_stop: assert property (p_stop) else $error("mode wrong");
    property p_rel; port_pins_released == stop; endproperty
    a_rel: assert property (p_rel) else $error("pins not released");
    property p_ctl;
        rd |-> {ctrl.async_clr_n, ctrl.tx_sync_clr, ctrl.rx_sync_clr} == {rdata[7], ~rdata[6:5]};
    endproperty
    a_ctl: assert property (p_ctl) else $error("clears wrong");
    property p_rx; !ctrl.clk_run [*2] |-> rx_data_to_core; endproperty
    a_rx: assert property (p_rx) else $error("input not high");
    property p_tx; ctrl.tx_sync_clr [*2] |-> serial_output_pin; endproperty
    a_tx: assert property (p_tx) else $error("output not idle");
    property p_oe; 1'b1 |=> serial_output_oe != $past(stop); endproperty
    a_oe: assert property (p_oe) else $error("enable late");
endmodule // upec_chk

// file: upec_remote.sv
// remote transceiver model: drives the port's input line, hears its output
// assumes the bench calls drive away from the rising edge
module upec_remote (
    input  wire logic clk,
    input  wire logic tx_line,
    output logic      line,
    output logic      heard
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'b1;
    always @(posedge clk) heard <= tx_line;
    task automatic drive(input logic b);
        line = b;
    endtask
endmodule // upec_remote

// file: testbench.sv
// testbench: mode register scenarios for the serial port control block
// assumes upec_chk and upec_remote are compiled before this file
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 txd = 1'b1;
    logic                 sin, sout, oe, rxc, rel, heard, gclk;
    logic [7:0]           rdata;
    logic [15:0]          raddr = 16'hff70;
    upec_pkg::upec_req_s  req = '0;
    upec_pkg::upec_ctrl_s ctrl;
    upec_pkg::upec_mode_e mode;
    int                   err_count = 0;
    int                   n_compared = 0;
    always #10 clk = ~clk;
    upec_ctrl upec_ctrl_i (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .raddr(raddr),
        .serial_input_pin(sin), .tx_data_from_core(txd), .serial_output_pin(sout),
        .serial_output_oe(oe), .rx_data_to_core(rxc), .port_pins_released(rel),
        .gated_clock(gclk), .ctrl(ctrl), .mode(mode));
    upec_remote upec_remote_i (.clk(clk), .tx_line(sout), .line(sin), .heard(heard));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic bw, input logic [2:0] sel, input logic [15:0] a,
                      input logic [7:0] d);
        @(negedge clk) req = '{1'b1, bw, sel, a, d};
        @(negedge clk) req.wr = 1'b0;
    endtask
    task automatic t_reset;
        chk({rdata, rel, mode == upec_pkg::UPEC_STOPPED, oe}, 16'h000e);
        $display("t_reset done");
    endtask
    task automatic t_start;
        wr(1'b0, 3'h0, 16'hff70, 8'h80);
        wr(1'b1, 3'h6, 16'hff70, 8'h01);
        wr(1'b1, 3'h5, 16'hff70, 8'h01);
        txd = 1'b0;
        upec_remote_i.drive(1'b0);
        repeat (4) @(negedge clk);
        chk({rdata, oe, sout, heard, rxc}, 16'h0e18);
        @(posedge clk) #1 chk(gclk, 16'h0001);
        $display("t_start done");
    endtask
    task automatic t_fields;
        wr(1'b0, 3'h0, 16'hff70, 8'hf4);
        chk({rdata, ctrl[3:0]}, 16'h0f5a);
        wr(1'b0, 3'h0, 16'hff70, 8'hfe);
        wr(1'b1, 3'h0, 16'hff70, 8'h00);
        wr(1'b0, 3'h0, 16'hff71, 8'h00);
        chk(rdata, 16'h00ff);
        raddr = 16'hff71;
        #1 chk(rdata, 16'h0000);
        @(negedge clk) raddr = 16'hff70;
        $display("t_fields done");
    endtask
    task automatic t_stop;
        wr(1'b1, 3'h6, 16'hff70, 8'h00);
        wr(1'b1, 3'h5, 16'hff70, 8'h00);
        chk({ctrl.tx_sync_clr, ctrl.rx_sync_clr, sout}, 16'h0007);
        wr(1'b1, 3'h7, 16'hff70, 8'h00);
        repeat (3) @(negedge clk);
        chk({rdata, ctrl.async_clr_n, rxc, rel}, 16'h00fb);
        @(posedge clk) #1 chk(gclk, 16'h0000);
        $display("t_stop done");
    endtask
    task automatic t_rereset;
        wr(1'b0, 3'h0, 16'hff70, 8'h80);
        wr(1'b1, 3'h6, 16'hff70, 8'h01);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk({rdata, oe, rxc, ctrl.async_clr_n}, 16'h000a);
        rst_n = 1'b1;
        wr(1'b0, 3'h0, 16'hff70, 8'h80);
        chk({rdata, rel}, 16'h0102);
        $display("t_rereset done");
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        t_reset;
        t_start;
        t_fields;
        t_stop;
        t_rereset;
        close_out;
    end
    initial begin
        #50000;
        err_count++;
        close_out;
    end
endmodule // testbench
bind upec_ctrl upec_chk upec_chk_i (.clk, .rst_n, .req, .rdata, .raddr, .serial_output_pin,
    .serial_output_oe, .rx_data_to_core, .port_pins_released, .ctrl, .mode);
